/* File: verilog/match_timer_defs.svh */
// Register offsets, field positions, reset values and timing counts of the match timer
`ifndef MATCH_TIMER_DEFS_SVH
`define MATCH_TIMER_DEFS_SVH

`define ADDR_AUTO_STOP 8'h00
`define ADDR_RUN 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_COMPARE 8'h0C
`define ADDR_CAPTURE 8'h10
`define ADDR_IRQ_STATUS 8'h14
`define ADDR_IRQ_MASK 8'h18

`define CTRL_ENABLE_BIT 15
`define CTRL_TOGGLE_BIT 7
`define CTRL_FORCE_HI 5
`define CTRL_FORCE_LO 4
`define CTRL_CLKSEL_BIT 0
`define AUTO_IDLE_BIT 0
`define AUTO_HALT_BIT 1

`define FORCE_INVERT 2'h0
`define FORCE_SET 2'h1
`define FORCE_CLEAR 2'h2
`define FORCE_NONE 2'h3

`define COUNT_RESET 16'h0000
`define SYNC_STAGES 2

`endif

/* File: verilog/match_timer_pkg.sv */
// Types shared by the match timer modules
package match_timer_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic counter_enable;
      logic toggle_enable;
      logic clk_select;
      logic idle_stop;
      logic halt_run;
   } timer_cfg_t;

   typedef enum logic [1:0] {
      FORCE_INV,
      FORCE_SET_LVL,
      FORCE_CLR_LVL,
      FORCE_IDLE
   } force_t;

endpackage

/* File: verilog/sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/10ps
module sync2 (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Level in and out
   input wire logic d_i,
   output logic q_o
);
   logic stage1;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= 1'b0;
         q_o <= 1'b0;
      end else begin
         stage1 <= d_i;
         q_o <= stage1;
      end
   end
endmodule

/* File: verilog/count_core.sv */
// Sixteen-bit up-counter with compare, load and match pulse
`timescale 1ns/10ps
module count_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic tick_i,
   input wire logic load_i,
   input wire logic [15:0] load_value_i,
   input wire logic [15:0] compare_i,
   // State
   output logic [15:0] count_o,
   output logic match_o
);
   `include "match_timer_defs.svh"

   wire hit = tick_i && (count_o == compare_i);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= `COUNT_RESET;
      end else if (load_i) begin
         count_o <= load_value_i; // R8
      end else if (hit) begin
         count_o <= `COUNT_RESET; // R10
      end else if (tick_i) begin
         count_o <= count_o + 16'h0001; // R10
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         match_o <= 1'b0;
      end else begin
         match_o <= hit; // R18
      end
   end
endmodule

/* File: verilog/match_timer.sv */
// Top of the 16-bit match timer with register port and interrupt
// How it works
// R1: Software sets the counter enable bit in control before use.
// R2: With toggle enable set, each compare match inverts the timer output.
// R3: Force field write 00 inverts, 01 sets, 10 clears, 11 nothing; reads 11.
// R4: Clock select zero counts system clock, one counts prescaler clock ticks.
// R5: A 16-bit read/write compare value is checked against the counter.
// R6: Software never programs the compare value to zero.
// R7: Reading capture returns the live counter value.
// R8: Writing capture loads the counter directly.
// R9: Software writes zero to capture before each start.
// R10: With run set, counter counts up, clears on match, keeps counting.
// R11: Every match raises the match interrupt.
// R12: Clearing run stops counting and holds the counter value.
// R13: Software changes control, compare, capture only while run is zero.
// R14: After reset the timer output is low.
// R15: When counting stops the timer output keeps its level.
// R16: Idle stop bit set pauses counting during system idle.
// R17: Halt bit zero pauses counting during debug halt.
// R18: Match pulse lasts one cycle, two cycles after the cycle the counter equals compare.
`timescale 1ns/10ps
module match_timer
   import match_timer_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Clock source and system state
   input wire logic prescaler_clock_i,
   input wire logic idle_mode_i,
   input wire logic debug_halt_i,
   // Outputs
   output logic timer_output_pin_o,
   output logic match_pulse_o,
   output logic irq_o
);
   `include "match_timer_defs.svh"

   // ==================================================
   // Reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==================================================
   // Input synchronisers
   logic presc_sync;
   logic idle_sync;
   logic halt_sync;
   logic presc_prev;

   sync2 u_sync_presc (
      .clk_i(clk_i),
      .nrst_i(rst_n),
      .d_i(prescaler_clock_i),
      .q_o(presc_sync)
   );

   sync2 u_sync_idle (
      .clk_i(clk_i),
      .nrst_i(rst_n),
      .d_i(idle_mode_i),
      .q_o(idle_sync)
   );

   sync2 u_sync_halt (
      .clk_i(clk_i),
      .nrst_i(rst_n),
      .d_i(debug_halt_i),
      .q_o(halt_sync)
   );

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         presc_prev <= 1'b0;
      end else begin
         presc_prev <= presc_sync;
      end
   end

   // ==================================================
   // Bus decode
   bus_req_t req;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   function automatic logic hit_write(input bus_req_t r, input logic [7:0] a);
      hit_write = r.wr && (r.addr == a);
   endfunction

   // ==================================================
   // Configuration registers
   timer_cfg_t cfg;
   logic run;
   logic [15:0] compare;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '0;
      end else if (hit_write(req, `ADDR_CONTROL)) begin
         cfg.counter_enable <= req.wdata[`CTRL_ENABLE_BIT];
         cfg.toggle_enable <= req.wdata[`CTRL_TOGGLE_BIT];
         cfg.clk_select <= req.wdata[`CTRL_CLKSEL_BIT];
      end else if (hit_write(req, `ADDR_AUTO_STOP)) begin
         cfg.idle_stop <= req.wdata[`AUTO_IDLE_BIT];
         cfg.halt_run <= req.wdata[`AUTO_HALT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
      end else if (hit_write(req, `ADDR_RUN)) begin
         run <= req.wdata[0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         compare <= 16'h0000;
      end else if (hit_write(req, `ADDR_COMPARE)) begin
         compare <= req.wdata[15:0]; // R5
      end
   end

   // ==================================================
   // Counting gate
   logic tick;
   logic paused;
   logic src_tick;

   always_comb begin
      paused = (cfg.idle_stop && idle_sync) // R16
            || (!cfg.halt_run && halt_sync); // R17
      src_tick = cfg.clk_select ? (presc_sync && !presc_prev) : 1'b1; // R4
      tick = run && cfg.counter_enable && !paused && src_tick; // R10 R12
   end

   // ==================================================
   // Counter
   logic [15:0] count;
   logic match;

   count_core u_core (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .tick_i(tick),
      .load_i(hit_write(req, `ADDR_CAPTURE)),
      .load_value_i(req.wdata[15:0]),
      .compare_i(compare),
      .count_o(count),
      .match_o(match)
   );

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         match_pulse_o <= 1'b0;
      end else begin
         match_pulse_o <= match; // R11 R18
      end
   end

   // ==================================================
   // Timer output
   logic [1:0] force_sel;
   assign force_sel = req.wdata[`CTRL_FORCE_HI:`CTRL_FORCE_LO];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer_output_pin_o <= 1'b0; // R14
      end else if (hit_write(req, `ADDR_CONTROL)) begin
         unique case (force_sel)
            `FORCE_INVERT: timer_output_pin_o <= ~timer_output_pin_o; // R3
            `FORCE_SET: timer_output_pin_o <= 1'b1; // R3
            `FORCE_CLEAR: timer_output_pin_o <= 1'b0; // R3
            `FORCE_NONE: timer_output_pin_o <= timer_output_pin_o; // R3
         endcase
      end else if (match && cfg.toggle_enable) begin
         timer_output_pin_o <= ~timer_output_pin_o; // R2 R15
      end
   end

   // ==================================================
   // Interrupt
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 8'h00;
      end else begin
         irq_status[7:1] <= 7'h00;
         if (match) begin
            irq_status[0] <= 1'b1; // R11
         end else if (hit_write(req, `ADDR_IRQ_STATUS) && req.wdata[0]) begin
            irq_status[0] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= 8'h00;
      end else if (hit_write(req, `ADDR_IRQ_MASK)) begin
         irq_mask <= {7'h00, req.wdata[0]};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ==================================================
   // Read back
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req.rd) begin
         unique case (req.addr)
            `ADDR_AUTO_STOP: next_rdata = {30'h0, cfg.halt_run, cfg.idle_stop};
            `ADDR_RUN: next_rdata = {31'h0, run};
            `ADDR_CONTROL: begin
               next_rdata[`CTRL_ENABLE_BIT] = cfg.counter_enable;
               next_rdata[`CTRL_TOGGLE_BIT] = cfg.toggle_enable;
               next_rdata[`CTRL_FORCE_HI:`CTRL_FORCE_LO] = `FORCE_NONE; // R3
               next_rdata[`CTRL_CLKSEL_BIT] = cfg.clk_select;
            end
            `ADDR_COMPARE: next_rdata = {16'h0000, compare};
            `ADDR_CAPTURE: next_rdata = {16'h0000, count}; // R7
            `ADDR_IRQ_STATUS: next_rdata = {24'h0, irq_status};
            `ADDR_IRQ_MASK: next_rdata = {24'h0, irq_mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= next_rdata;
      end
   end
endmodule

/* File: bench/match_timer_assertions.sv */
// Port checker for the match timer
`timescale 1ns/10ps
`include "match_timer_defs.svh"
module match_timer_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // Outputs
   input wire logic timer_output_pin_o,
   input wire logic match_pulse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ====
   // Control writes
   sequence ctrl_wr;
      wr_i && addr_i == `ADDR_CONTROL;
   endsequence
   a_force_set: assert property (ctrl_wr ##0 wdata_i[5:4] == `FORCE_SET |=> timer_output_pin_o)
      else $error("pin not set by force");
   a_force_clear: assert property (ctrl_wr ##0 wdata_i[5:4] == `FORCE_CLEAR |=> !timer_output_pin_o)
      else $error("pin not cleared by force");
   a_force_invert: assert property (ctrl_wr ##0 wdata_i[5:4] == `FORCE_INVERT |=> $changed(timer_output_pin_o))
      else $error("pin not inverted by force");
   a_force_none: assert property (ctrl_wr ##0 wdata_i[5:4] == `FORCE_NONE |=> $stable(timer_output_pin_o) || match_pulse_o)
      else $error("pin moved on idle force");
   // ====
   // Output and readback
   a_pin_cause: assert property ($changed(timer_output_pin_o) |-> $past(wr_i && addr_i == `ADDR_CONTROL) || match_pulse_o)
      else $error("pin changed without cause");
   a_pulse_single: assert property (match_pulse_o |=> !match_pulse_o)
      else $error("match pulse too long");
   a_force_reads: assert property (rd_i && addr_i == `ADDR_CONTROL |=> rdata_o[5:4] == 2'h3)
      else $error("force field not read as 11");
   a_upper_zero: assert property (rd_i && (addr_i == `ADDR_COMPARE || addr_i == `ADDR_CAPTURE) |=> rdata_o[31:16] == 16'h0000)
      else $error("upper half not zero");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h00000000)
      else $error("read data outside read slot");
endmodule
bind match_timer match_timer_checker match_timer_checker_inst (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .timer_output_pin_o, .match_pulse_o);

/* File: bench/testbench.sv */
// Self-checking bench for the match timer
`timescale 1ns/10ps
`include "match_timer_defs.svh"
module testbench;
   logic clk_i, nrst_i, wr_i, rd_i, idle_mode_i, debug_halt_i;
   logic prescaler_clock_i, timer_output_pin_o, match_pulse_o, irq_o;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, q;
   logic [2:0] pdiv;
   int n_mismatch, n_tests, n;
   match_timer match_timer_inst (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .prescaler_clock_i, .idle_mode_i, .debug_halt_i, .timer_output_pin_o, .match_pulse_o, .irq_o);
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Prescaler clock, one rising edge per 8 cycles
   always @(posedge clk_i) pdiv <= nrst_i ? pdiv + 3'h1 : 3'h0;
   assign prescaler_clock_i = pdiv[2];
   // ====
   // Shared tasks
   task give_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
   endtask
   task wp(input int lim);
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
         if (n > lim) begin
            n_mismatch++;
            give_verdict;
         end
      end while (match_pulse_o !== 1'b1);
   endtask
   // ====
   // Scenarios
   task t_reset;
      chk("pin", 32'h0, timer_output_pin_o);
      rd(`ADDR_CONTROL);
      chk("ctrl", 32'h30, q);
      rd(`ADDR_COMPARE);
      chk("cmp", 32'h0, q);
      rd(8'h1C);
      chk("unmapped", 32'h0, q);
      wr(`ADDR_CAPTURE, 32'hBEEF);
      rd(`ADDR_CAPTURE);
      chk("cap", 32'hBEEF, q);
   endtask
   task t_run(input logic sel, input int exp);
      logic p;
      wr(`ADDR_CONTROL, 32'h80B0 | sel);
      wr(`ADDR_COMPARE, 32'h3);
      wr(`ADDR_CAPTURE, 32'h0);
      wr(`ADDR_IRQ_MASK, 32'h1);
      wr(`ADDR_RUN, 32'h1);
      wp(300);
      p = timer_output_pin_o;
      wp(300);
      chk("period", exp, n);
      chk("toggle", !p, timer_output_pin_o);
      wr(`ADDR_RUN, 32'h0);
      chk("irq", 32'h1, irq_o);
      wr(`ADDR_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_i);
      #1 chk("irq clr", 32'h0, irq_o);
   endtask
   task t_mask;
      logic p;
      wr(`ADDR_CONTROL, 32'h8030);
      wr(`ADDR_IRQ_MASK, 32'h0);
      wr(`ADDR_CAPTURE, 32'h0);
      p = timer_output_pin_o;
      wr(`ADDR_RUN, 32'h1);
      wp(20);
      wr(`ADDR_RUN, 32'h0);
      chk("no toggle", p, timer_output_pin_o);
      chk("masked", 32'h0, irq_o);
      rd(`ADDR_IRQ_STATUS);
      chk("status", 32'h1, q);
      wr(`ADDR_IRQ_STATUS, 32'h1);
   endtask
   task t_force;
      logic e;
      for (int c = 3; c >= 0; c--) begin
         e = c == 0 ? !timer_output_pin_o : c == 1 ? 1'b1 : c == 2 ? 1'b0 : timer_output_pin_o;
         wr(`ADDR_CONTROL, 32'h8000 | c << 4);
         chk("force", e, timer_output_pin_o);
      end
      rd(`ADDR_CONTROL);
      chk("ctrl rd", 32'h8030, q);
   endtask
   task t_pause(input logic [31:0] stop);
      @(posedge clk_i);
      idle_mode_i <= stop[0];
      debug_halt_i <= !stop[0];
      wr(`ADDR_CONTROL, 32'h8030);
      wr(`ADDR_AUTO_STOP, stop);
      wr(`ADDR_CAPTURE, 32'h0);
      wr(`ADDR_RUN, 32'h1);
      repeat (10) @(posedge clk_i);
      rd(`ADDR_CAPTURE);
      chk("paused", 32'h0, q);
      @(posedge clk_i);
      idle_mode_i <= 1'b0;
      debug_halt_i <= 1'b0;
      wp(20);
      wr(`ADDR_RUN, 32'h0);
      rd(`ADDR_CAPTURE);
      p_hold(q);
   endtask
   task p_hold(input logic [31:0] v);
      repeat (5) @(posedge clk_i);
      rd(`ADDR_CAPTURE);
      chk("held", v, q);
   endtask
   initial begin
      nrst_i = 1'b0;
      {wr_i, rd_i, idle_mode_i, debug_halt_i} = 4'h0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_reset;
      t_run(1'b0, 4);
      t_run(1'b1, 32);
      t_mask;
      t_force;
      t_pause(32'h1);
      t_pause(32'h0);
      give_verdict;
   end
endmodule
